// ### verilog/csd_pkg.sv
// constants and types shared by the clock source and divider control block
package csd_pkg;
	// timing
	localparam int CLK_PERIOD_NS      = 10;
	localparam int XTAL_SETTLE_CYCLES = 992;
	localparam int WAKE_MIN_US        = 60;
	localparam int WAKE_EXTRA_CYCLES  = (WAKE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_TOTAL_CYCLES  = XTAL_SETTLE_CYCLES + WAKE_EXTRA_CYCLES;
	localparam int DIV_MAX_RATIO      = 510;
	// frequencies
	localparam longint CPU_CORE_CLOCK_MAX_HZ       = 64'h0000_0000_00B7_1B00; // 12 MHz
	localparam longint CPU_CORE_CLOCK_LOW_POWER_HZ = 64'h0000_0000_007A_1200; // 8 MHz
	localparam longint RC_NOMINAL_HZ     = 64'h0000_0000_0070_80E8; // 7.373 MHz
	localparam longint WDT_OSC_HZ        = 64'h0000_0000_0006_1A80; // 400 kHz
	localparam longint XTAL_LOW_MAX_HZ   = 64'h0000_0000_0001_86A0; // 100 kHz
	localparam longint XTAL_MED_MAX_HZ   = 64'h0000_0000_003D_0900; // 4 MHz
	localparam longint EXT_CLK_MAX_HZ    = 64'h0000_0000_00B7_1B00; // 12 MHz
	// widths
	localparam int DIV_W  = 8;
	localparam int TRIM_W = 6;
	// register word indices (byte address is four times the index)
	localparam logic [2:0] REG_DIVIDER = 3'h0;
	localparam logic [2:0] REG_AUX     = 3'h1;
	localparam logic [2:0] REG_TRIM    = 3'h2;
	localparam logic [2:0] REG_STATUS  = 3'h3;
	// field positions
	localparam int AUX_LOW_POWER_BIT  = 7;
	localparam int TRIM_CLKOUT_EN_BIT = 6;
	localparam int STAT_SRC_LSB       = 0;
	localparam int STAT_WAKE_BIT      = 3;
	localparam int STAT_CLKOUT_BIT    = 4;
	localparam int STAT_RC_RUN_BIT    = 5;
	localparam int STAT_OVER_MAX_BIT  = 6;
	localparam int STAT_ABOVE_LP_BIT  = 7;
	// reset values
	localparam logic [7:0]  DIVIDER_RESET   = 8'h00;
	localparam logic        LOW_POWER_RESET = 1'b0;
	localparam logic        CLKOUT_EN_POR   = 1'b0;
	localparam logic [31:0] READ_UNMAPPED   = 32'h0000_0000;
	// nonvolatile clock source codes
	localparam logic [2:0] SRC_RC        = 3'h0;
	localparam logic [2:0] SRC_WDT       = 3'h1;
	localparam logic [2:0] SRC_EXT       = 3'h2;
	localparam logic [2:0] SRC_XTAL_LOW  = 3'h4;
	localparam logic [2:0] SRC_XTAL_MED  = 3'h5;
	localparam logic [2:0] SRC_XTAL_HIGH = 3'h6;
	// crystal amplifier range codes
	localparam logic [1:0] RANGE_LOW  = 2'h0;
	localparam logic [1:0] RANGE_MED  = 2'h1;
	localparam logic [1:0] RANGE_HIGH = 2'h2;
	localparam logic [1:0] RANGE_OFF  = 2'h3;

	typedef enum logic [1:0] {ST_CFG, ST_WAKE, ST_RUN, ST_DOWN} csd_state_type;
endpackage : csd_pkg

// ### verilog/csd_clock_divider.sv
// cpu clock divider producing one tick per cpu clock period
`timescale 1ns/100ps
`default_nettype none
module csd_clock_divider #(
	parameter int DIV_W = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             enable,
	input  wire logic [DIV_W-1:0] div_value,
	output logic                  tick,
	output logic [DIV_W-1:0]      active_div
);
	logic [DIV_W:0] cnt;
	logic [DIV_W:0] limit;
	logic           wrap;

	// zero passes every cycle, n gives a period of 2n cycles
	assign limit = {active_div, 1'b0} - {{DIV_W{1'b0}}, 1'b1}; // R18 R3
	assign wrap  = (active_div == '0) || (cnt == limit); // R18

	// new setting is taken only where a cpu period ends, and every cycle while disabled
	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			cnt        <= '0;
			tick       <= 1'b0;
			active_div <= rst_n ? div_value : '0;
		end else if (wrap) begin
			cnt        <= '0;
			tick       <= 1'b1;
			active_div <= div_value; // R19 R4
		end else begin
			cnt        <= cnt + {{DIV_W{1'b0}}, 1'b1};
			tick       <= 1'b0;
		end
	end

	// period bookkeeping for the checks below
	logic [DIV_W+1:0] since;
	logic [DIV_W+1:0] len;
	logic             seen;
	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			since <= '0;
			len   <= '0;
			seen  <= 1'b0;
		end else if (wrap) begin
			since <= {{(DIV_W+1){1'b0}}, 1'b1};
			len   <= (div_value == '0) ? {{(DIV_W+1){1'b0}}, 1'b1} : {1'b0, div_value, 1'b0};
			seen  <= 1'b1;
		end else begin
			since <= since + {{(DIV_W+1){1'b0}}, 1'b1};
		end
	end

	chk_div_period: assert property (@(posedge clk) disable iff (!rst_n || !enable) // R3 R18
		(wrap && seen) |-> (since == len))
		else $error("cpu clock period does not match divider setting");

	chk_div_boundary: assert property (@(posedge clk) disable iff (!rst_n) // R19
		($changed(active_div) && $past(enable) && enable) |-> tick)
		else $error("divider setting changed inside a cpu period");
endmodule : csd_clock_divider
`default_nettype wire

// ### verilog/csd_clock_control.sv
// clock source selection, cpu clock divider, wake-up delay and clock output
//
// Operation
// R1: machine cycle spans two cpu clocks
// R2: peripheral clock runs at half cpu clock
// R3: cpu clock divider reaches ratio 510
// R4: divider changes never stop execution
// R5: internal rc oscillator usable as source
// R6: six-bit trim loaded at reset, writable
// R7: watchdog oscillator selectable as source
// R8: source chosen by nonvolatile bits only
// R9: crystal offers low, medium, high ranges
// R10: low-power bit clears on every reset
// R11: clock output only when crystal unused
// R12: trim register bit enables clock output
// R13: external clock runs 0 to 12 MHz
// R14: crystal wake holds cpu 992 cycles plus
// R15: cpu clock limited to 12 MHz
// R16: only power-on reset reloads trim
// R17: rc stops in power-down unless rtc
// R18: zero passes through, n divides 2n
// R19: divider change lands on cpu boundary
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module csd_clock_control #(
	parameter int     WAKE_CYCLES = csd_pkg::WAKE_TOTAL_CYCLES,
	parameter longint OSC_HZ      = csd_pkg::CPU_CORE_CLOCK_MAX_HZ
) (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        POWER_ON_RESET,
	input  wire logic [2:0]  CFG_CLOCK_SOURCE,
	input  wire logic [5:0]  FACTORY_TRIM,
	input  wire logic        POWER_DOWN,
	input  wire logic        RTC_ENABLE,
	input  wire logic        RTC_ON_CRYSTAL,
	input  wire logic [2:0]  ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [31:0] WRITEDATA,
	input  wire logic [3:0]  BYTEENABLE,
	output logic [31:0]      READDATA,
	output logic             WAITREQUEST,
	output logic             CPU_CLK_TICK,
	output logic             MACHINE_CYCLE,
	output logic             PERIPH_CLK,
	output logic             CLKOUT_O,
	output logic             CLKOUT_OE,
	output logic             RC_OSC_ENABLE,
	output logic [5:0]       RC_TRIM,
	output logic             WDT_OSC_ENABLE,
	output logic             XTAL_OSC_ENABLE,
	output logic [1:0]       XTAL_RANGE,
	output logic             LOW_POWER_CLOCK,
	output logic             CPU_HOLD
);
	csd_pkg::csd_state_type state;
	logic [15:0]                    wake_cnt;
	logic [2:0]                     src;
	logic [csd_pkg::DIV_W-1:0]      cpu_clock_divider;
	logic [csd_pkg::DIV_W-1:0]      active_div;
	logic [csd_pkg::TRIM_W-1:0]     trim;
	logic                           clock_output_enable;
	logic                           low_power_clock_flag;
	logic                           src_is_xtal;
	logic                           clkout_allowed;
	logic                           clkout_run;
	logic                           cpu_tick;
	logic                           mc_phase;
	logic                           over_max;
	logic                           above_lp;
	logic                           wr_go;
	logic [31:0]                    next_rdata;
	logic [9:0]                     divisor;

	assign src_is_xtal    = src[2]; // R9
	assign clkout_allowed = !src_is_xtal && !RTC_ON_CRYSTAL; // R11
	assign clkout_run     = clkout_allowed && clock_output_enable; // R12
	assign wr_go          = WRITE && !WAITREQUEST;
	assign divisor        = (active_div == '0) ? 10'h001 : {1'b0, active_div, 1'b0};

	// wake-up sequence: crystal sources wait for settling before cpu runs
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			state    <= csd_pkg::ST_CFG;
			wake_cnt <= '0;
		end else begin
			case (state)
				csd_pkg::ST_CFG: begin
					wake_cnt <= '0;
					state    <= CFG_CLOCK_SOURCE[2] ? csd_pkg::ST_WAKE : csd_pkg::ST_RUN;
				end
				csd_pkg::ST_WAKE: begin
					if (POWER_DOWN) begin
						state <= csd_pkg::ST_DOWN;
					end else if (wake_cnt == 16'(WAKE_CYCLES - 1)) begin
						state <= csd_pkg::ST_RUN; // R14
					end else begin
						wake_cnt <= wake_cnt + 16'h0001; // R14
					end
				end
				csd_pkg::ST_RUN: begin
					if (POWER_DOWN) begin
						state <= csd_pkg::ST_DOWN;
					end
				end
				csd_pkg::ST_DOWN: begin
					wake_cnt <= '0;
					if (!POWER_DOWN) begin
						state <= src_is_xtal ? csd_pkg::ST_WAKE : csd_pkg::ST_RUN; // R14
					end
				end
				default: begin
					state <= csd_pkg::ST_CFG;
				end
			endcase
		end
	end

	// clock source strap caught once, right after reset release
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			src <= csd_pkg::SRC_RC;
		end else if (state == csd_pkg::ST_CFG) begin
			src <= CFG_CLOCK_SOURCE; // R8
		end
	end

	// oscillator enables and crystal range follow the strapped source
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			RC_OSC_ENABLE   <= 1'b0;
			WDT_OSC_ENABLE  <= 1'b0;
			XTAL_OSC_ENABLE <= 1'b0;
			XTAL_RANGE      <= csd_pkg::RANGE_OFF;
		end else begin
			RC_OSC_ENABLE   <= (src == csd_pkg::SRC_RC) &&
				(state != csd_pkg::ST_DOWN || RTC_ENABLE); // R5 R17
			WDT_OSC_ENABLE  <= (src == csd_pkg::SRC_WDT) && (state != csd_pkg::ST_DOWN); // R7
			XTAL_OSC_ENABLE <= (src_is_xtal || RTC_ON_CRYSTAL) && (state != csd_pkg::ST_DOWN);
			case (src)
				csd_pkg::SRC_XTAL_LOW:  XTAL_RANGE <= csd_pkg::RANGE_LOW; // R9
				csd_pkg::SRC_XTAL_MED:  XTAL_RANGE <= csd_pkg::RANGE_MED; // R9
				csd_pkg::SRC_XTAL_HIGH: XTAL_RANGE <= csd_pkg::RANGE_HIGH; // R9
				default:                XTAL_RANGE <= csd_pkg::RANGE_OFF;
			endcase
		end
	end

	// cpu clock divider, enabled only while running
	csd_clock_divider #(
		.DIV_W      (csd_pkg::DIV_W)
	) u_divider (
		.clk        (MCLK),
		.rst_n      (RESET_N),
		.enable     (state == csd_pkg::ST_RUN), // R14
		.div_value  (cpu_clock_divider), // R3 R4
		.tick       (cpu_tick),
		.active_div (active_div)
	);
	assign CPU_CLK_TICK = cpu_tick;

	// peripheral clock, machine cycle strobe and clock output pin
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			mc_phase      <= 1'b0;
			MACHINE_CYCLE <= 1'b0;
			PERIPH_CLK    <= 1'b0;
			CLKOUT_O      <= 1'b0;
			CLKOUT_OE     <= 1'b0;
			CPU_HOLD      <= 1'b1;
		end else begin
			MACHINE_CYCLE <= cpu_tick && mc_phase; // R1
			CLKOUT_OE     <= clkout_run; // R11 R12
			CPU_HOLD      <= (state != csd_pkg::ST_RUN); // R14
			if (cpu_tick) begin
				mc_phase   <= !mc_phase; // R1
				PERIPH_CLK <= !PERIPH_CLK; // R2
			end
			if (!clkout_run) begin
				CLKOUT_O <= 1'b0;
			end else if (cpu_tick) begin
				CLKOUT_O <= !CLKOUT_O; // R12
			end
		end
	end

	// divider register: any reset clears it, writes land any time
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			cpu_clock_divider <= csd_pkg::DIVIDER_RESET;
		end else if (wr_go && ADDRESS == csd_pkg::REG_DIVIDER && BYTEENABLE[0]) begin
			cpu_clock_divider <= WRITEDATA[7:0]; // R4
		end
	end

	// low-power flag in the auxiliary function register
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			low_power_clock_flag <= csd_pkg::LOW_POWER_RESET; // R10
		end else if (wr_go && ADDRESS == csd_pkg::REG_AUX && BYTEENABLE[0]) begin
			low_power_clock_flag <= WRITEDATA[csd_pkg::AUX_LOW_POWER_BIT];
		end
	end

	// trim and clock output enable survive all but power-on reset
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			if (POWER_ON_RESET) begin
				trim                <= FACTORY_TRIM; // R6 R16
				clock_output_enable <= csd_pkg::CLKOUT_EN_POR;
			end
		end else if (wr_go && ADDRESS == csd_pkg::REG_TRIM && BYTEENABLE[0]) begin
			trim                <= WRITEDATA[csd_pkg::TRIM_W-1:0]; // R6
			clock_output_enable <= WRITEDATA[csd_pkg::TRIM_CLKOUT_EN_BIT]; // R12
		end
	end

	// cpu clock against the 12 MHz ceiling and the 8 MHz low-power bound
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			over_max <= 1'b0;
			above_lp <= 1'b0;
		end else begin
			over_max <= 64'(OSC_HZ) > (64'(csd_pkg::CPU_CORE_CLOCK_MAX_HZ) * 64'(divisor)); // R15
			above_lp <= 64'(OSC_HZ) > (64'(csd_pkg::CPU_CORE_CLOCK_LOW_POWER_HZ) * 64'(divisor)); // R10
		end
	end

	// flop copies for the pins
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			RC_TRIM         <= '0;
			LOW_POWER_CLOCK <= csd_pkg::LOW_POWER_RESET;
		end else begin
			RC_TRIM         <= trim; // R5
			LOW_POWER_CLOCK <= low_power_clock_flag;
		end
	end

	// read data selection, unmapped words read as zero
	always_comb begin
		next_rdata = csd_pkg::READ_UNMAPPED;
		case (ADDRESS)
			csd_pkg::REG_DIVIDER: next_rdata[7:0] = cpu_clock_divider;
			csd_pkg::REG_AUX:     next_rdata[csd_pkg::AUX_LOW_POWER_BIT] = low_power_clock_flag;
			csd_pkg::REG_TRIM: begin
				next_rdata[csd_pkg::TRIM_W-1:0]         = trim;
				next_rdata[csd_pkg::TRIM_CLKOUT_EN_BIT] = clock_output_enable;
			end
			csd_pkg::REG_STATUS: begin
				next_rdata[csd_pkg::STAT_SRC_LSB +: 3]  = src;
				next_rdata[csd_pkg::STAT_WAKE_BIT]     = (state == csd_pkg::ST_WAKE);
				next_rdata[csd_pkg::STAT_CLKOUT_BIT]   = clkout_run;
				next_rdata[csd_pkg::STAT_RC_RUN_BIT]   = RC_OSC_ENABLE;
				next_rdata[csd_pkg::STAT_OVER_MAX_BIT] = over_max;
				next_rdata[csd_pkg::STAT_ABOVE_LP_BIT] = above_lp;
			end
			default: next_rdata = csd_pkg::READ_UNMAPPED;
		endcase
	end

	// avalon slave: one wait cycle, then a one-cycle answer
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			WAITREQUEST <= 1'b1;
			READDATA    <= csd_pkg::READ_UNMAPPED;
		end else begin
			WAITREQUEST <= !((READ || WRITE) && WAITREQUEST);
			if (READ && WAITREQUEST) begin
				READDATA <= next_rdata;
			end
		end
	end

	// helper: cpu ticks since the last machine cycle strobe
	logic [1:0] ticks_in_mc;
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			ticks_in_mc <= '0;
		end else if (MACHINE_CYCLE) begin
			ticks_in_mc <= cpu_tick ? 2'h1 : 2'h0;
		end else if (cpu_tick && ticks_in_mc != 2'h3) begin
			ticks_in_mc <= ticks_in_mc + 2'h1;
		end
	end

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	chk_mcycle_two_clocks: assert property (MACHINE_CYCLE |-> ticks_in_mc == 2'h2) // R1
		else $error("machine cycle not two cpu clocks");
	chk_pclk_half_rate: assert property (cpu_tick |=> PERIPH_CLK != $past(PERIPH_CLK)) // R2
		else $error("peripheral clock missed a toggle");
	chk_pclk_stable: assert property (!cpu_tick |=> $stable(PERIPH_CLK)) // R2
		else $error("peripheral clock toggled without cpu tick");
	chk_trim_keep: assert property (@(posedge MCLK) disable iff (1'b0) // R16
		(!RESET_N && !POWER_ON_RESET) |=> trim == $past(trim))
		else $error("trim changed on a non power-on reset");
	chk_trim_por_load: assert property (@(posedge MCLK) disable iff (1'b0) // R6
		(!RESET_N && POWER_ON_RESET) |=> trim == $past(FACTORY_TRIM))
		else $error("trim not loaded on power-on reset");
	chk_low_power_reset: assert property ($rose(RESET_N) |-> !low_power_clock_flag) // R10
		else $error("low-power flag set after reset");
	chk_clkout_gate: assert property (!clkout_allowed |=> !CLKOUT_OE && !CLKOUT_O) // R11
		else $error("clock output driven while crystal in use");
	chk_clkout_rate: assert property ((clkout_run && CLKOUT_OE && cpu_tick) // R12
		|=> CLKOUT_O != $past(CLKOUT_O))
		else $error("clock output did not follow cpu clock");
	chk_rc_stop: assert property ((state == csd_pkg::ST_DOWN && // R17
		!(src == csd_pkg::SRC_RC && RTC_ENABLE)) |=> !RC_OSC_ENABLE)
		else $error("rc oscillator running in power-down");
	chk_hold_no_tick: assert property (state != csd_pkg::ST_RUN |=> !cpu_tick) // R14
		else $error("cpu clock ran during hold-off");
	chk_wake_early: assert property ((state == csd_pkg::ST_WAKE && // R14
		wake_cnt < 16'(WAKE_CYCLES - 1)) |=> state != csd_pkg::ST_RUN)
		else $error("wake delay ended early");
	chk_wake_end: assert property ((state == csd_pkg::ST_WAKE && !POWER_DOWN && // R14
		wake_cnt == 16'(WAKE_CYCLES - 1)) |=> state == csd_pkg::ST_RUN)
		else $error("wake delay did not end on time");
	chk_src_fixed: assert property (state != csd_pkg::ST_CFG |=> $stable(src)) // R8
		else $error("clock source changed at run time");
endmodule : csd_clock_control
`default_nettype wire

// ### verification/csd_osc_partner.sv
// model of the crystal or external clock source at the oscillator pins
`timescale 1ns/100ps
`default_nettype none
module csd_osc_partner (
	input  wire logic       clk,
	input  wire logic       xtal_enable,
	input  wire logic [1:0] xtal_range,
	input  wire logic       clkout_o,
	input  wire logic       clkout_oe,
	output logic            pin_level,
	output logic            osc_running
);
	// source rate kept inside the 0 to 12 MHz span
	localparam longint SRC_HZ = csd_pkg::EXT_CLK_MAX_HZ;
	logic last_pin = 1'b0;

	// amplifier only oscillates when enabled on a real range
	assign osc_running = xtal_enable && (xtal_range != csd_pkg::RANGE_OFF)
		&& (SRC_HZ <= csd_pkg::EXT_CLK_MAX_HZ);
	// released pin shows inverse of last level, never a stale value
	assign pin_level = clkout_oe ? clkout_o : ~last_pin;
	always @(posedge clk) begin
		last_pin <= pin_level;
	end
endmodule : csd_osc_partner
`default_nettype wire

// ### verification/csd_clock_control_bench.sv
// testbench for the clock source and divider control block
`timescale 1ns/100ps
`default_nettype none
module csd_clock_control_bench;
	localparam int WAKE  = 20;
	localparam int LIMIT = 30000;
	logic        MCLK, RESET_N, POWER_ON_RESET, POWER_DOWN, RTC_ENABLE, RTC_ON_CRYSTAL;
	logic        READ, WRITE, WAITREQUEST, CPU_CLK_TICK, MACHINE_CYCLE, PERIPH_CLK;
	logic        CLKOUT_O, CLKOUT_OE, RC_OSC_ENABLE, WDT_OSC_ENABLE, XTAL_OSC_ENABLE;
	logic        LOW_POWER_CLOCK, CPU_HOLD, pin_level, osc_running, last_pc, last_pin;
	logic [2:0]  CFG_CLOCK_SOURCE, ADDRESS;
	logic [5:0]  FACTORY_TRIM, RC_TRIM;
	logic [1:0]  XTAL_RANGE;
	logic [3:0]  BYTEENABLE;
	logic [31:0] WRITEDATA, READDATA;
	logic [7:0]  d;
	logic [2:0]  srcs [6];
	logic [1:0]  rngs [6];
	int          checks, fail_count, cyc, tk_cnt, mc_cnt, pc_cnt, pin_cnt, n, dt, dm, dp, dq;

	csd_clock_control #(.WAKE_CYCLES(WAKE), .OSC_HZ(csd_pkg::CPU_CORE_CLOCK_MAX_HZ)) uut (
		.MCLK(MCLK), .RESET_N(RESET_N), .POWER_ON_RESET(POWER_ON_RESET),
		.CFG_CLOCK_SOURCE(CFG_CLOCK_SOURCE), .FACTORY_TRIM(FACTORY_TRIM),
		.POWER_DOWN(POWER_DOWN), .RTC_ENABLE(RTC_ENABLE), .RTC_ON_CRYSTAL(RTC_ON_CRYSTAL),
		.ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
		.BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
		.CPU_CLK_TICK(CPU_CLK_TICK), .MACHINE_CYCLE(MACHINE_CYCLE), .PERIPH_CLK(PERIPH_CLK),
		.CLKOUT_O(CLKOUT_O), .CLKOUT_OE(CLKOUT_OE), .RC_OSC_ENABLE(RC_OSC_ENABLE),
		.RC_TRIM(RC_TRIM), .WDT_OSC_ENABLE(WDT_OSC_ENABLE), .XTAL_OSC_ENABLE(XTAL_OSC_ENABLE),
		.XTAL_RANGE(XTAL_RANGE), .LOW_POWER_CLOCK(LOW_POWER_CLOCK), .CPU_HOLD(CPU_HOLD));
	csd_osc_partner partner (.clk(MCLK), .xtal_enable(XTAL_OSC_ENABLE),
		.xtal_range(XTAL_RANGE), .clkout_o(CLKOUT_O), .clkout_oe(CLKOUT_OE),
		.pin_level(pin_level), .osc_running(osc_running));

	always #5 MCLK = ~MCLK;

	// event counters and hang limit
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (CPU_CLK_TICK === 1'b1) tk_cnt <= tk_cnt + 1;
		if (MACHINE_CYCLE === 1'b1) mc_cnt <= mc_cnt + 1;
		if (PERIPH_CLK !== last_pc) pc_cnt <= pc_cnt + 1;
		if (pin_level !== last_pin && CLKOUT_OE === 1'b1) pin_cnt <= pin_cnt + 1;
		last_pc <= PERIPH_CLK;
		last_pin <= pin_level;
		if (cyc == LIMIT) begin
			fail_count++;
			report_and_stop();
		end
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one bus cycle, held until waitrequest is sampled low
	task bus(input logic wr, input logic [2:0] a, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge MCLK);
		ADDRESS <= a;
		WRITE <= wr;
		READ <= ~wr;
		WRITEDATA <= {24'h00_0000, wd};
		BYTEENABLE <= 4'h1;
		do @(posedge MCLK); while (WAITREQUEST !== 1'b0);
		rd = READDATA[7:0];
		WRITE <= 1'b0;
		READ <= 1'b0;
	endtask : bus

	task do_reset(input logic por, input logic [2:0] src, output int hold);
		@(posedge MCLK);
		RESET_N <= 1'b0;
		POWER_ON_RESET <= por;
		CFG_CLOCK_SOURCE <= src;
		repeat (10) @(posedge MCLK);
		RESET_N <= 1'b1;
		POWER_ON_RESET <= 1'b0;
		hold = 0;
		do begin @(posedge MCLK); hold++; end while (CPU_HOLD !== 1'b0 && hold < 200);
	endtask : do_reset

	task tick_gap(output int g);
		@(posedge MCLK);
		while (CPU_CLK_TICK !== 1'b1) @(posedge MCLK);
		g = 0;
		do begin @(posedge MCLK); g++; end while (CPU_CLK_TICK !== 1'b1 && g < 600);
	endtask : tick_gap

	task window(input int len);
		int t0, m0, p0, q0;
		t0 = tk_cnt; m0 = mc_cnt; p0 = pc_cnt; q0 = pin_cnt;
		repeat (len) @(posedge MCLK);
		dt = tk_cnt - t0; dm = mc_cnt - m0; dp = pc_cnt - p0; dq = pin_cnt - q0;
	endtask : window

	initial begin
		MCLK = 0; RESET_N = 0; POWER_ON_RESET = 1; CFG_CLOCK_SOURCE = csd_pkg::SRC_RC;
		FACTORY_TRIM = 6'h2A; POWER_DOWN = 0; RTC_ENABLE = 0; RTC_ON_CRYSTAL = 0;
		ADDRESS = 3'h0; READ = 0; WRITE = 0; WRITEDATA = 32'h0000_0000; BYTEENABLE = 4'h0;
		checks = 0; fail_count = 0; cyc = 0; tk_cnt = 0; mc_cnt = 0; pc_cnt = 0; pin_cnt = 0;
		last_pc = 0; last_pin = 0;
		srcs = '{csd_pkg::SRC_RC, csd_pkg::SRC_WDT, csd_pkg::SRC_EXT,
			csd_pkg::SRC_XTAL_LOW, csd_pkg::SRC_XTAL_MED, csd_pkg::SRC_XTAL_HIGH};
		rngs = '{csd_pkg::RANGE_OFF, csd_pkg::RANGE_OFF, csd_pkg::RANGE_OFF,
			csd_pkg::RANGE_LOW, csd_pkg::RANGE_MED, csd_pkg::RANGE_HIGH};
		// power-on reset loads factory trim, clears flags
		do_reset(1'b1, csd_pkg::SRC_RC, n);
		check("rc hold", n <= 4, 1);
		check("rc enable", RC_OSC_ENABLE, 1);
		check("trim pin", RC_TRIM, 6'h2A);
		bus(0, csd_pkg::REG_TRIM, 8'h00, d); check("trim reg", d, 8'h2A);
		bus(0, csd_pkg::REG_AUX, 8'h00, d); check("aux reg", d, 8'h00);
		bus(0, csd_pkg::REG_STATUS, 8'h00, d); check("source", d[2:0], csd_pkg::SRC_RC);
		check("above 8 MHz", d[7], 1);
		check("above 12 MHz", d[6], 0);
		bus(0, 3'h5, 8'h00, d); check("unmapped", d, 8'h00);
		// divider table: old or new gap at the change, then new gap
		foreach (srcs[i]) begin
			automatic int dv = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 3 : 255;
			automatic int old = n;
			bus(1, csd_pkg::REG_DIVIDER, dv[7:0], d);
			tick_gap(n);
			check("gap at change", n == old || n == ((dv == 0) ? 1 : 2 * dv) || i == 0, 1);
			tick_gap(n);
			check("tick gap", n, (dv == 0) ? 1 : 2 * dv);
			check("no stall", CPU_HOLD, 0);
			if (i == 3) break;
		end
		bus(1, csd_pkg::REG_DIVIDER, 8'h01, d);
		// the long 255 period must end before the new setting shows
		tick_gap(n);
		check("gap div one", n, 2);
		bus(0, csd_pkg::REG_STATUS, 8'h00, d); check("above 8 MHz div", d[7], 0);
		window(200);
		check("machine cycles", dm * 2 + 2 >= dt && dm * 2 <= dt + 2, 1);
		check("periph clock", dp + 1 >= dt && dp <= dt + 1 && dt > 90, 1);
		// clock output enabled through the trim register
		bus(1, csd_pkg::REG_TRIM, 8'h55, d);
		repeat (3) @(posedge MCLK);
		check("trim write", RC_TRIM, 6'h15);
		check("clkout on", CLKOUT_OE, 1);
		window(200);
		check("clkout rate", dq + 1 >= dt && dq <= dt + 1 && dt > 90, 1);
		RTC_ON_CRYSTAL <= 1'b1;
		repeat (4) @(posedge MCLK);
		check("clkout rtc xtal", CLKOUT_OE, 0);
		RTC_ON_CRYSTAL <= 1'b0;
		bus(1, csd_pkg::REG_AUX, 8'h80, d);
		bus(0, csd_pkg::REG_AUX, 8'h00, d); check("low power reg", d, 8'h80);
		check("low power pin", LOW_POWER_CLOCK, 1);
		// power-down keeps rc only when selected and rtc enabled
		POWER_DOWN <= 1'b1;
		repeat (6) @(posedge MCLK);
		check("rc stop", RC_OSC_ENABLE, 0);
		window(20);
		check("no ticks down", dt, 0);
		RTC_ENABLE <= 1'b1;
		repeat (6) @(posedge MCLK);
		check("rc kept", RC_OSC_ENABLE, 1);
		POWER_DOWN <= 1'b0;
		RTC_ENABLE <= 1'b0;
		// warm resets through every source code
		foreach (srcs[i]) begin
			do_reset(1'b0, srcs[i], n);
			if (srcs[i][2]) check("wake", n >= WAKE + 2 && n <= WAKE + 6, 1);
			else check("no wake", n <= 4, 1);
			check("wdt enable", WDT_OSC_ENABLE, srcs[i] == csd_pkg::SRC_WDT);
			check("range", XTAL_RANGE, rngs[i]);
			check("osc running", osc_running, srcs[i][2]);
			check("clkout source", CLKOUT_OE, !srcs[i][2]);
			bus(0, csd_pkg::REG_STATUS, 8'h00, d); check("source", d[2:0], srcs[i]);
			bus(0, csd_pkg::REG_AUX, 8'h00, d); check("aux warm", d, 8'h00);
			bus(0, csd_pkg::REG_TRIM, 8'h00, d); check("trim kept", d, 8'h55);
		end
		do_reset(1'b1, csd_pkg::SRC_RC, n);
		bus(0, csd_pkg::REG_TRIM, 8'h00, d); check("trim reload", d, 8'h2A);
		report_and_stop();
	end
endmodule : csd_clock_control_bench
`default_nettype wire
